// ### design/rcs_pkg.sv
// package for the run command source selector: source codes, input roles, timing.
// assumes a single 100 MHz system clock shared by every user of these names.
package rcs_pkg;

    // command source settings
    localparam logic [2:0] SRC_KEYPAD = 3'h0;
    localparam logic [2:0] SRC_TWO_WIRE = 3'h1; // two_wire_terminal_mode
    localparam logic [2:0] SRC_RUN_DIR = 3'h2;  // run_dir_terminal_mode
    localparam logic [2:0] SRC_SERIAL = 3'h3;
    localparam logic [2:0] SRC_FIELDBUS = 3'h4;
    localparam logic [2:0] SRC_PLC = 3'h5;

    // multi-function input role codes
    localparam int NUM_INPUTS = 11;
    localparam logic [4:0] FN_FWD = 5'h01;
    localparam logic [4:0] FN_REV = 5'h02;
    localparam logic [4:0] FN_RUN_ENABLE = 5'h0d;
    localparam logic [4:0] FN_FORWARD_JOG_INPUT = 5'h0e;
    localparam logic [4:0] FN_REVERSE_JOG_INPUT = 5'h0f;
    localparam logic [4:0] FN_PREMAG = 5'h10;

    // keypad multi-function key role
    localparam logic [1:0] MKEY_LOCAL_REMOTE = 2'h1;

    // direction lockout settings
    localparam logic [1:0] LOCK_NONE = 2'h0;
    localparam logic [1:0] LOCK_FWD = 2'h1;
    localparam logic [1:0] LOCK_REV = 2'h2;

    // start delay: counted in hundredths of a second, 0.00..100.00 s, default 1.00 s
    localparam int CLK_HZ = 100_000_000;
    localparam int DELAY_UNIT_MS = 10;
    localparam int DELAY_UNIT_CYCLES = CLK_HZ / 1000 * DELAY_UNIT_MS;
    localparam logic [13:0] DELAY_MAX = 14'h2710;
    localparam logic [13:0] DELAY_DEFAULT = 14'h0064;

    // serial link settings
    localparam logic [7:0] STATION_MAX = 8'hfa;
    localparam logic [2:0] RATE_DEFAULT = 3'h3; // 9600 bit/s
    localparam int RATE_1200 = 1200;

    // one run command
    typedef struct packed {
        logic run;
        logic rev;
    } rcs_cmd_t;

endpackage : rcs_pkg

// ### design/rcs_selector.sv
// run command source selector: turns keypad, terminal, serial, fieldbus and plc commands
// into one run request with a direction.
// assumes keys and terminals are raw pins; digital source commands come from same-clock logic.
//
// Behaviour
// - run commands come from the source picked by the command-source setting 0..5.
// - keypad mode: forward or reverse key starts, stop key stops.
// - two-wire mode: only forward runs forward, only reverse runs reverse, else stop.
// - input role code 1 makes a terminal forward run, code 2 reverse run.
// - run-direction mode: forward input runs, reverse input only selects direction.
// - terminal start waits a settable delay, 0.00 to 100 s, default 1.00 s.
// - host commands over serial link; station 0..250, rate 1200..38400, default 9600.
// - multi-key role 1 toggles remote and local each press; indicator shows mode.
// - local takes keypad commands, ignores jog, needs run-enable input if one is assigned.
// - remote follows the configured sources without altering settings.
// - remote to local stops the motor and reports keypad for command and frequency.
// - local to remote with terminal source follows the terminals after a new start delay.
// - local to remote with a digital source stops, restarts on the next command.
// - without power-on run, inputs active at power-up block terminal runs until all clear.
// - after trip reset, terminal runs stay blocked until all inputs clear and run again.
// - lockout 0 allows both, 1 prevents forward, 2 prevents reverse.
`timescale 1ns/1ns

module rcs_selector #(
    parameter int DELAY_UNIT_CYCLES = rcs_pkg::DELAY_UNIT_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [2:0] cmd_source,
    input wire logic [rcs_pkg::NUM_INPUTS-1:0] term_pins,
    input wire logic [rcs_pkg::NUM_INPUTS-1:0][4:0] input_function_code,
    input wire logic key_fwd,
    input wire logic key_rev,
    input wire logic key_stop,
    input wire logic key_multi,
    input wire logic [1:0] multi_key_role,
    input wire logic [13:0] run_on_delay,
    input wire logic power_on_run,
    input wire logic trip_reset,
    input wire logic [1:0] direction_lockout,
    input wire rcs_pkg::rcs_cmd_t serial_cmd,
    input wire rcs_pkg::rcs_cmd_t fieldbus_cmd,
    input wire rcs_pkg::rcs_cmd_t plc_cmd,
    input wire logic [7:0] serial_station_number,
    input wire logic [2:0] serial_bit_rate,
    output rcs_pkg::rcs_cmd_t run_out,
    output logic local_mode,
    output logic [2:0] cmd_source_shown,
    output logic freq_source_keypad,
    output logic jog_allowed,
    output logic [7:0] station_number,
    output logic [16:0] serial_bit_cycles
);

    // true when any synchronised terminal carrying the given role is on
    function automatic logic role_on(
        input logic [rcs_pkg::NUM_INPUTS-1:0] pins,
        input logic [rcs_pkg::NUM_INPUTS-1:0][4:0] codes,
        input logic [4:0] code
    );
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < rcs_pkg::NUM_INPUTS; i++) begin
            hit = hit | (pins[i] & (codes[i] == code));
        end
        return hit;
    endfunction : role_on

    // true when any terminal is given the role at all
    function automatic logic role_used(
        input logic [rcs_pkg::NUM_INPUTS-1:0][4:0] codes,
        input logic [4:0] code
    );
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < rcs_pkg::NUM_INPUTS; i++) begin
            hit = hit | (codes[i] == code);
        end
        return hit;
    endfunction : role_used

    // two-flop synchronisers for terminals and keys
    // raw pins only reach the decode through both flops
    logic [rcs_pkg::NUM_INPUTS+3:0] sync_a;
    logic [rcs_pkg::NUM_INPUTS+3:0] sync_b;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {key_multi, key_stop, key_rev, key_fwd, term_pins};
            sync_b <= sync_a;
        end
    end

    wire [rcs_pkg::NUM_INPUTS-1:0] pins = sync_b[rcs_pkg::NUM_INPUTS-1:0];
    wire k_fwd = sync_b[rcs_pkg::NUM_INPUTS];
    wire k_rev = sync_b[rcs_pkg::NUM_INPUTS+1];
    wire k_stop = sync_b[rcs_pkg::NUM_INPUTS+2];
    wire k_multi = sync_b[rcs_pkg::NUM_INPUTS+3];

    // key edge history and previous digital run levels
    logic k_fwd_q;
    logic k_rev_q;
    logic k_multi_q;
    logic dig_run_q;
    rcs_pkg::rcs_cmd_t dig_sel;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            k_fwd_q <= 1'b0;
            k_rev_q <= 1'b0;
            k_multi_q <= 1'b0;
            dig_run_q <= 1'b0;
        end else begin
            k_fwd_q <= k_fwd;
            k_rev_q <= k_rev;
            k_multi_q <= k_multi;
            dig_run_q <= dig_sel.run;
        end
    end

    // terminal role decode
    // jog and premagnetise roles only feed the lockout release checks
    wire t_fwd = role_on(pins, input_function_code, rcs_pkg::FN_FWD);
    wire t_rev = role_on(pins, input_function_code, rcs_pkg::FN_REV);
    wire t_jog = role_on(pins, input_function_code, rcs_pkg::FN_FORWARD_JOG_INPUT)
        | role_on(pins, input_function_code, rcs_pkg::FN_REVERSE_JOG_INPUT);
    wire t_premag = role_on(pins, input_function_code, rcs_pkg::FN_PREMAG);
    wire t_en_on = role_on(pins, input_function_code, rcs_pkg::FN_RUN_ENABLE);
    wire t_en_used = role_used(input_function_code, rcs_pkg::FN_RUN_ENABLE);
    wire any_op = t_fwd | t_rev | t_jog | t_premag;

    // key and mode events
    // a held forward, reverse or multi key gives one press; holding it does nothing more
    wire fwd_press = k_fwd & ~k_fwd_q;
    wire rev_press = k_rev & ~k_rev_q;
    wire toggle = k_multi & ~k_multi_q & (multi_key_role == rcs_pkg::MKEY_LOCAL_REMOTE);
    wire to_local = toggle & ~local_mode;
    wire to_remote = toggle & local_mode;

    // terminal command by mode
    // the reverse input never starts the motor in run-direction mode
    wire is_two_wire = cmd_source == rcs_pkg::SRC_TWO_WIRE;
    wire is_run_dir = cmd_source == rcs_pkg::SRC_RUN_DIR;
    wire is_term = is_two_wire | is_run_dir;
    wire tw_run = t_fwd ^ t_rev;
    wire tw_rev = t_rev & ~t_fwd;
    wire term_run = is_two_wire ? tw_run : t_fwd;
    wire term_rev = is_two_wire ? tw_rev : t_rev;

    // digital source select; other codes give an idle command here
    assign dig_sel = (cmd_source == rcs_pkg::SRC_SERIAL) ? serial_cmd
        : (cmd_source == rcs_pkg::SRC_FIELDBUS) ? fieldbus_cmd
        : (cmd_source == rcs_pkg::SRC_PLC) ? plc_cmd
        : '0;
    wire dig_rise = dig_sel.run & ~dig_run_q;

    // keypad run latch
    // stop acts on its level, so a held stop key keeps the drive stopped
    logic kp_run;
    logic kp_rev;
    wire next_kp_run = (k_stop | to_local | to_remote) ? 1'b0
        : (fwd_press | rev_press) ? 1'b1 : kp_run;
    wire next_kp_rev = rev_press ? 1'b1 : fwd_press ? 1'b0 : kp_rev;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            kp_run <= 1'b0;
            kp_rev <= 1'b0;
        end else begin
            kp_run <= next_kp_run;
            kp_rev <= next_kp_rev;
        end
    end

    // local/remote mode and digital re-arm gate
    // a digital source still asserting run on the way back to remote
    // must drop and raise it again before the drive restarts
    logic dig_armed;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            local_mode <= 1'b0;
            dig_armed <= 1'b1;
        end else begin
            local_mode <= local_mode ^ toggle;
            if (dig_rise) begin
                dig_armed <= 1'b1;
            end else if (to_remote) begin
                dig_armed <= 1'b0;
            end
        end
    end

    // power-up and trip lockouts; a set wins over the clear
    // the synchronisers show reset zeros for two edges, so the power-up
    // check waits until the pins have really reached the decode
    logic [1:0] pwr_cnt;
    logic pwr_block;
    logic trip_block;
    wire pwr_settled = pwr_cnt == 2'h2; // two synchroniser edges
    wire pwr_release = ~any_op | power_on_run;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwr_cnt <= 2'h0;
            pwr_block <= 1'b1;
            trip_block <= 1'b0;
        end else begin
            if (!pwr_settled) begin
                pwr_cnt <= pwr_cnt + 2'h1;
                pwr_block <= 1'b1; // held until the inputs have settled
            end else if (pwr_block && pwr_release) begin
                pwr_block <= 1'b0;
            end
            if (trip_reset) begin
                trip_block <= 1'b1;
            end else if (!any_op) begin
                trip_block <= 1'b0;
            end
        end
    end
    wire term_blocked = pwr_block | trip_block;

    // start delay counter for terminal runs
    // the count restarts whenever the request drops, so a bouncing contact
    // only starts the motor once it has stood for the whole delay
    logic [19:0] tick_cnt;
    logic [13:0] delay_cnt;
    logic term_running;
    wire delay_limit = run_on_delay > rcs_pkg::DELAY_MAX;
    wire [13:0] delay_set = delay_limit ? rcs_pkg::DELAY_MAX : run_on_delay;
    wire term_want = is_term & ~local_mode & term_run & ~term_blocked;
    wire tick = tick_cnt == 20'(DELAY_UNIT_CYCLES - 1);
    wire delay_done = delay_cnt >= delay_set;
    wire next_term_running = term_want & (term_running | delay_done);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt <= '0;
            delay_cnt <= '0;
            term_running <= 1'b0;
        end else begin
            term_running <= next_term_running;
            if (!term_want || term_running) begin
                tick_cnt <= '0;
                delay_cnt <= '0;
            end else if (tick) begin
                tick_cnt <= '0;
                delay_cnt <= delay_cnt + 14'h0001;
            end else begin
                tick_cnt <= tick_cnt + 20'h00001;
            end
        end
    end

    // final command: local keypad, or remote source, then direction lockout
    wire en_ok = ~t_en_used | t_en_on;
    wire kp_src = cmd_source == rcs_pkg::SRC_KEYPAD;
    wire rem_run = is_term ? term_running
        : kp_src ? kp_run
        : dig_sel.run & dig_armed;
    wire rem_rev = is_term ? term_rev : kp_src ? kp_rev : dig_sel.rev;
    wire sel_run = local_mode ? (kp_run & en_ok) : rem_run;
    wire sel_rev = local_mode ? kp_rev : rem_rev;
    // a locked direction turns into a stop, never into the other direction
    wire fwd_locked = (direction_lockout == rcs_pkg::LOCK_FWD) & ~sel_rev;
    wire rev_locked = (direction_lockout == rcs_pkg::LOCK_REV) & sel_rev;
    wire dir_locked = fwd_locked | rev_locked;
    rcs_pkg::rcs_cmd_t next_run_out;
    assign next_run_out.run = sel_run & ~dir_locked;
    assign next_run_out.rev = sel_rev;

    // serial settings: station clamp and bit period lookup
    // rate codes above the table fall back to the default rate
    wire [2:0] rate_code = (serial_bit_rate > 3'h5) ? rcs_pkg::RATE_DEFAULT : serial_bit_rate;
    wire [16:0] next_bit_cycles =
        17'((rcs_pkg::CLK_HZ / rcs_pkg::RATE_1200) >> rate_code);
    wire [7:0] next_station = (serial_station_number > rcs_pkg::STATION_MAX)
        ? rcs_pkg::STATION_MAX : serial_station_number;

    // registered outputs
    // every port below leaves straight from a flop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            run_out <= '0;
            cmd_source_shown <= rcs_pkg::SRC_KEYPAD;
            freq_source_keypad <= 1'b0;
            jog_allowed <= 1'b0;
            station_number <= '0;
            serial_bit_cycles <= '0;
        end else begin
            run_out <= next_run_out;
            cmd_source_shown <= local_mode ? rcs_pkg::SRC_KEYPAD : cmd_source;
            freq_source_keypad <= local_mode;
            jog_allowed <= ~local_mode;
            station_number <= next_station;
            serial_bit_cycles <= next_bit_cycles;
        end
    end

endmodule : rcs_selector

// ### tb/rcs_host.sv
// serial host model: sets the run command word that arrives over the serial link.
// assumes the bench calls send(); the word changes only at a falling edge and then holds.
`timescale 1ns/1ns
module rcs_host (
    input wire logic clk,
    output rcs_pkg::rcs_cmd_t serial_cmd
);
    // host word, held until the next request
    initial serial_cmd = '0;
    task automatic send(input logic run, input logic rev);
        @(negedge clk);
        serial_cmd = '{run: run, rev: rev};
    endtask : send
endmodule : rcs_host

// ### tb/rcs_selector_chk.sv
// checker for the run command source selector, watching its top ports only.
// assumes one clock domain with the async active-low reset.
`timescale 1ns/1ns
module rcs_selector_chk (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [2:0] cmd_source,
    input wire logic key_stop,
    input wire logic [1:0] direction_lockout,
    input wire rcs_pkg::rcs_cmd_t serial_cmd,
    input wire logic [7:0] serial_station_number,
    input wire logic [2:0] serial_bit_rate,
    input wire rcs_pkg::rcs_cmd_t run_out,
    input wire logic local_mode,
    input wire logic [2:0] cmd_source_shown,
    input wire logic freq_source_keypad,
    input wire logic jog_allowed,
    input wire logic [7:0] station_number,
    input wire logic [16:0] serial_bit_cycles
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // expected bit time and clamped station
    wire logic [2:0] rate_eff = (serial_bit_rate > 3'h5) ? 3'h3 : serial_bit_rate;
    wire logic [16:0] bit_exp = 17'h14585 >> rate_eff;
    wire logic [7:0] stn_exp = (serial_station_number > 8'hfa) ? 8'hfa : serial_station_number;
    a_local_keypad: assert property (
        local_mode && $past(local_mode) |-> cmd_source_shown == 3'h0 && freq_source_keypad
        && !jog_allowed) else $error("local mode not shown as keypad");
    a_remote_source: assert property (
        !local_mode && !$past(local_mode) && $past(rst_b, 2) && $stable(cmd_source)
        |-> cmd_source_shown == cmd_source) else $error("remote source not shown");
    a_station_clamp: assert property (
        $past(rst_b, 2) && $stable(serial_station_number) |-> station_number == stn_exp)
        else $error("station number wrong");
    a_bit_time: assert property (
        $past(rst_b, 2) && $stable(serial_bit_rate) |-> serial_bit_cycles == bit_exp)
        else $error("bit time wrong");
    a_no_forward: assert property (
        direction_lockout == 2'h1 && $past(direction_lockout) == 2'h1
        && $past(direction_lockout, 2) == 2'h1 |-> !(run_out.run && !run_out.rev))
        else $error("forward run while locked");
    a_no_reverse: assert property (
        direction_lockout == 2'h2 && $past(direction_lockout) == 2'h2
        && $past(direction_lockout, 2) == 2'h2 |-> !(run_out.run && run_out.rev))
        else $error("reverse run while locked");
    a_local_stops: assert property (
        $rose(local_mode) |-> ##[0:2] !run_out.run) else $error("no stop on going local");
    a_stop_key: assert property (
        (local_mode && key_stop)[*5] |-> !run_out.run) else $error("stop key ignored");
    a_serial_idle: assert property (
        !local_mode && !$past(local_mode) && cmd_source == 3'h3 && !serial_cmd.run
        |=> !run_out.run) else $error("run without serial command");
endmodule : rcs_selector_chk

// ### tb/rcs_selector_tb.sv
// self-checking bench for the run command source selector.
// assumes a 100 MHz clock and a start-delay unit shortened to 4 cycles.
`timescale 1ns/1ns
module rcs_selector_tb;
    localparam rcs_pkg::rcs_cmd_t FWD = 2'h2, REV = 2'h3, STOP = 2'h0;
    logic clk = 1'b0, rst_b = 1'b0, power_on_run = 1'b0, trip_reset = 1'b0;
    logic [2:0] cmd_source = 3'h0, serial_bit_rate = 3'h0;
    logic [10:0] term_pins = '0;
    logic [10:0][4:0] input_function_code = '0;
    logic [3:0] keys = '0;
    logic [1:0] multi_key_role = 2'h1, direction_lockout = 2'h0;
    logic [13:0] run_on_delay = 14'h0002;
    logic [7:0] serial_station_number = 8'h00, station_number;
    rcs_pkg::rcs_cmd_t serial_cmd, fieldbus_cmd = '0, plc_cmd = '0, run_out;
    logic local_mode, freq_source_keypad, jog_allowed;
    logic [2:0] cmd_source_shown;
    logic [16:0] serial_bit_cycles;
    int errors = 0, n_compared = 0;
    // clock, design and host
    always #5 clk = ~clk;
    rcs_selector #(.DELAY_UNIT_CYCLES(4)) i_dut (.clk, .rst_b, .cmd_source, .term_pins,
        .input_function_code, .key_fwd(keys[0]), .key_rev(keys[1]), .key_stop(keys[2]),
        .key_multi(keys[3]), .multi_key_role, .run_on_delay, .power_on_run, .trip_reset,
        .direction_lockout, .serial_cmd, .fieldbus_cmd, .plc_cmd, .serial_station_number,
        .serial_bit_rate, .run_out, .local_mode, .cmd_source_shown, .freq_source_keypad,
        .jog_allowed, .station_number, .serial_bit_cycles);
    rcs_host i_host (.clk, .serial_cmd);
    // a stopped request only needs run low
    function automatic logic ok(input rcs_pkg::rcs_cmd_t e);
        return e.run ? run_out === e : run_out.run === 1'b0;
    endfunction : ok
    task automatic chk_cmd(input rcs_pkg::rcs_cmd_t e);
        n_compared++;
        if (!ok(e)) begin
            errors++;
            $display("[ERR] %0t exp %h got %h", $time, e, run_out);
        end
    endtask : chk_cmd
    task automatic chk_val(input logic [16:0] e, input logic [16:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask : chk_val
    task automatic final_report;
        if (errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // bounded wait for a request, then judge it
    task automatic wait_cmd(input rcs_pkg::rcs_cmd_t e);
        int i;
        for (i = 0; i < 300 && !ok(e); i++) cyc(1);
        chk_cmd(e);
        if (i == 300) final_report();
    endtask : wait_cmd
    task automatic press(input int k, input int n);
        keys[k] = 1'b1;
        cyc(n);
        keys[k] = 1'b0;
        cyc(2);
    endtask : press
    task automatic t_keypad;
        cmd_source = rcs_pkg::SRC_KEYPAD;
        press(0, 3);
        wait_cmd(FWD);
        press(2, 5);
        wait_cmd(STOP);
        press(1, 3);
        wait_cmd(REV);
        press(2, 5);
        wait_cmd(STOP);
    endtask : t_keypad
    task automatic t_two_wire;
        cmd_source = rcs_pkg::SRC_TWO_WIRE;
        term_pins[1:0] = 2'b01;
        cyc(7);
        chk_cmd(STOP);
        wait_cmd(FWD);
        term_pins[1:0] = 2'b11;
        wait_cmd(STOP);
        term_pins[1:0] = 2'b10;
        wait_cmd(REV);
        term_pins[1:0] = 2'b00;
        wait_cmd(STOP);
    endtask : t_two_wire
    task automatic t_run_dir;
        cmd_source = rcs_pkg::SRC_RUN_DIR;
        term_pins[1:0] = 2'b10;
        cyc(20);
        chk_cmd(STOP);
        term_pins[1:0] = 2'b11;
        wait_cmd(REV);
        term_pins[1:0] = 2'b01;
        wait_cmd(FWD);
        term_pins[1:0] = 2'b00;
        wait_cmd(STOP);
    endtask : t_run_dir
    task automatic t_digital;
        cmd_source = rcs_pkg::SRC_SERIAL;
        i_host.send(1'b1, 1'b1);
        wait_cmd(REV);
        i_host.send(1'b0, 1'b0);
        wait_cmd(STOP);
        fieldbus_cmd = FWD;
        cmd_source = rcs_pkg::SRC_FIELDBUS;
        wait_cmd(FWD);
        plc_cmd = FWD;
        cmd_source = rcs_pkg::SRC_PLC;
        direction_lockout = rcs_pkg::LOCK_FWD;
        wait_cmd(STOP);
        plc_cmd = REV;
        wait_cmd(REV);
        direction_lockout = rcs_pkg::LOCK_REV;
        wait_cmd(STOP);
        direction_lockout = rcs_pkg::LOCK_NONE;
        wait_cmd(REV);
        plc_cmd = STOP;
        wait_cmd(STOP);
    endtask : t_digital
    task automatic t_settings;
        for (int r = 0; r < 8; r++) begin
            serial_bit_rate = 3'(r);
            serial_station_number = (r > 5) ? 8'hf5 + 8'(r) : 8'(r * 50);
            cyc(3);
            chk_val(17'h14585 >> ((r > 5) ? 3 : r), serial_bit_cycles);
            chk_val({9'h0, (r > 5) ? 8'hfa : 8'(r * 50)}, {9'h0, station_number});
        end
    endtask : t_settings
    task automatic t_local;
        cmd_source = rcs_pkg::SRC_TWO_WIRE;
        term_pins[1:0] = 2'b01;
        wait_cmd(FWD);
        press(3, 3);
        wait_cmd(STOP);
        chk_val({13'h0, local_mode, cmd_source_shown != 3'h0, jog_allowed, freq_source_keypad},
            17'h9);
        press(1, 3);
        wait_cmd(REV);
        press(2, 6);
        wait_cmd(STOP);
        press(0, 3);
        wait_cmd(FWD);
        term_pins[1:0] = 2'b10;
        press(3, 3);
        wait_cmd(REV);
        chk_val({15'h0, local_mode, freq_source_keypad}, 17'h0);
    endtask : t_local
    task automatic t_lockouts;
        trip_reset = 1'b1;
        cyc(1);
        trip_reset = 1'b0;
        wait_cmd(STOP);
        cyc(30);
        chk_cmd(STOP);
        term_pins[1:0] = 2'b00;
        cyc(8);
        term_pins[1:0] = 2'b01;
        wait_cmd(FWD);
        rst_b = 1'b0;
        cyc(3);
        rst_b = 1'b1;
        cyc(30);
        chk_cmd(STOP);
        term_pins[1:0] = 2'b00;
        cyc(8);
        term_pins[1:0] = 2'b01;
        wait_cmd(FWD);
        power_on_run = 1'b1;
        rst_b = 1'b0;
        cyc(3);
        rst_b = 1'b1;
        wait_cmd(FWD);
    endtask : t_lockouts
    task automatic t_enable;
        input_function_code[2] = rcs_pkg::FN_RUN_ENABLE;
        press(3, 3);
        press(0, 3);
        cyc(4);
        chk_cmd(STOP);
        term_pins[2] = 1'b1;
        wait_cmd(FWD);
        term_pins[2] = 1'b0;
        wait_cmd(STOP);
        press(3, 3);
        wait_cmd(FWD);
        input_function_code[2] = 5'h00;
    endtask : t_enable
    // main sequence
    initial begin
        input_function_code[0] = rcs_pkg::FN_FWD;
        input_function_code[1] = rcs_pkg::FN_REV;
        cyc(5);
        rst_b = 1'b1;
        cyc(3);
        t_keypad();
        t_two_wire();
        t_run_dir();
        t_digital();
        t_settings();
        t_local();
        t_lockouts();
        t_enable();
        final_report();
    end
endmodule : rcs_selector_tb
bind rcs_selector rcs_selector_chk i_chk (.clk, .rst_b, .cmd_source, .key_stop,
    .direction_lockout, .serial_cmd, .serial_station_number, .serial_bit_rate, .run_out,
    .local_mode, .cmd_source_shown, .freq_source_keypad, .jog_allowed, .station_number,
    .serial_bit_cycles);
